// ---- hw/clksw_pkg.sv ----
// Purpose: shared constants and types for the clock source switch
// Assumes: one 40 MHz clock, registers reached over AXI4-Lite
// Notes: oscillators arrive as raw pin levels and are sampled
package clksw_pkg;
  // register byte offsets
  localparam logic [31:0] OSC_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] T1_CTRL_OFS = 32'h0000_0004;
  // field positions
  localparam int IDLE_BIT = 7;
  localparam int START_FLAG_BIT = 3;
  localparam int T1ACT_BIT = 6;
  localparam int T1EN_BIT = 3;
  // select field codes
  localparam logic [1:0] SEL_RC = 2'h3;
  localparam logic [1:0] SEL_PRI = 2'h2;
  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_DFLT = 2'h0;
  // values after reset
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic IDLE_RST = 1'b0;
  localparam logic DFLT_BIT_RST = 1'b1;
  // cycle counts
  localparam logic [10:0] START_CYCLES = 11'h400;
  localparam logic [1:0] OLD_TICKS = 2'h2;
  localparam logic [1:0] NEW_TICKS = 2'h3;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // clock sources, index into the tick vector
  typedef enum logic [1:0] {
    SRC_PRI = 2'h0,
    SRC_SEC = 2'h1,
    SRC_RC = 2'h2
  } clksw_src_t;
  // switch sequencer states
  typedef enum logic [2:0] {
    SW_RUN = 3'h1,
    SW_OLD = 3'h2,
    SW_NEW = 3'h4
  } clksw_sw_state_t;
endpackage

// ---- hw/clksw_sw_if.sv ----
// Purpose: link between control logic and switch sequencer
// Assumes: same clock on both sides
// Notes: tick holds one-cycle source edges
`timescale 1ns/100ps
interface clksw_sw_if;
  import clksw_pkg::*;
  logic [2:0] tick; // source edges, pri/sec/rc
  clksw_src_t reqSrc; // wanted source
  clksw_src_t curSrc; // source now in use
  logic gateOn; // device clock passed through
  modport ctl(output tick, output reqSrc, input curSrc,
              input gateOn);
  modport sw(input tick, input reqSrc, output curSrc,
             output gateOn);
endinterface

// ---- hw/clksw_switch.sv ----
// Purpose: glitch-free handover between clock sources
// Assumes: ticks are clean single-cycle edges
// Notes: clock stays gated for the whole handover
`timescale 1ns/100ps
module clksw_switch
  import clksw_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control side
  clksw_sw_if.sw sw
);
  // whole sequencer state
  typedef struct packed {
    clksw_sw_state_t st;
    clksw_src_t cur;
    clksw_src_t nxt;
    logic [1:0] cnt;
    logic gate;
  } clksw_sw_t;
  // boot on the RC source with the gate open
  localparam clksw_sw_t SW_RST = '{SW_RUN, SRC_RC, SRC_RC,
                                   2'h0, 1'b1};
  clksw_sw_t q, d;

  // next state
  always_comb begin
    d = q;
    case (q.st)
      SW_RUN: begin
        if (sw.reqSrc != q.cur) begin
          d.st = SW_OLD;
          d.nxt = sw.reqSrc;
          d.cnt = 2'h0;
          d.gate = 1'b0;
        end
      end
      SW_OLD: begin
        // request seen on old edges before letting go
        if (sw.tick[q.cur]) begin
          if (q.cnt == OLD_TICKS - 2'h1) begin
            d.st = SW_NEW;
            d.cur = q.nxt;
            d.cnt = 2'h0;
          end else begin
            d.cnt = q.cnt + 2'h1;
          end
        end
      end
      SW_NEW: begin
        // edge sampling adds up to one more new cycle
        if (sw.tick[q.cur]) begin
          if (q.cnt == NEW_TICKS - 2'h1) begin
            d.st = SW_RUN;
            d.gate = 1'b1;
          end else begin
            d.cnt = q.cnt + 2'h1;
          end
        end
      end
      default: d = SW_RST;
    endcase
    if (sys_rst) begin
      d = SW_RST;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign sw.curSrc = q.cur;
  assign sw.gateOn = q.gate;

  // checks
  sequence s_handover;
    q.st == SW_OLD ##1 q.st == SW_NEW;
  endsequence
  a_pause_gated:
    assert property (@(posedge mclk) disable iff (sys_rst)
      q.st != SW_RUN |-> !q.gate)
    else $error("clock not gated during handover");
  a_handover_swap:
    assert property (@(posedge mclk) disable iff (sys_rst)
      s_handover |-> q.cur == $past(q.nxt) && q.cnt == 2'h0)
    else $error("new source not taken on handover");
  a_new_count:
    assert property (@(posedge mclk) disable iff (sys_rst)
      q.st == SW_NEW && sw.tick[q.cur] && q.cnt == 2'h2
      |=> q.st == SW_RUN && q.gate)
    else $error("gate not reopened after three new edges");
endmodule // clksw_switch

// ---- hw/clksw_top.sv ----
// Purpose: system clock source selection with status flags
// Assumes: oscillator and config pins are asynchronous
// Notes: device clock is a clock enable on mclk
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module clksw_top
  import clksw_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // axi write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // oscillator pins
  input wire logic priOscIn,
  input wire logic secOscIn,
  input wire logic rcOscIn,
  // configuration pins
  input wire logic cfgLoadedIn,
  input wire logic resetClockDefaultIn,
  input wire logic hsModeIn,
  input wire logic twoSpeedIn,
  // processor core
  input wire logic sleepExec,
  input wire logic wakeEvent,
  // clock outputs and power state
  output logic devClkEn,
  output logic [1:0] clkSrc,
  output logic idleMode,
  output logic sleepMode,
  output logic timer1OscRun,
  output logic rcOscRun
);
  // whole block state
  typedef struct packed {
    logic [6:0] s1; // first sync stage
    logic [6:0] s2; // second sync stage
    logic [2:0] s3; // edge history of oscillators
    logic idle; // idle_on_sleep
    logic [1:0] sel; // system_clock_select
    logic t1en; // timer1_osc_enable
    logic dfltBit; // reset_clock_default_bit
    logic cfgDone; // configuration loaded
    logic [10:0] startCnt; // start_up_timer
    logic startDone; // start-up count finished
    logic startFlag; // primary_start_timeout_flag
    logic t1Act; // timer1_clock_active
    logic slp;
    logic idl;
    logic clkEn;
    logic awHeld;
    logic [31:0] awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wEn;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } clksw_top_t;
  clksw_top_t q, d;
  clksw_src_t reqSrc;
  logic [2:0] tickS; // clean oscillator edges
  logic hsS; // synced high-speed crystal mode
  logic priReady;

  clksw_sw_if swIf();

  // handover sequencer
  clksw_switch clksw_switch_i (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sw(swIf)
  );

  // edges read the second and third stages only
  assign tickS = q.s2[2:0] & ~q.s3;
  assign hsS = q.s2[5];
  assign priReady = !hsS || q.startDone;
  assign swIf.tick = tickS;
  assign swIf.reqSrc = reqSrc;

  // source wanted from the select field
  always_comb begin
    reqSrc = swIf.curSrc;
    if (!q.cfgDone) begin
      reqSrc = SRC_RC;
    end else begin
      case (q.sel)
        SEL_RC: reqSrc = SRC_RC;
        SEL_PRI: reqSrc = SRC_PRI;
        SEL_SEC: begin
          // refused while the Timer1 oscillator is off
          if (q.t1en) begin
            reqSrc = SRC_SEC;
          end
        end
        default: reqSrc = q.dfltBit ? SRC_PRI : SRC_RC;
      endcase
      // primary waits for the start-up timer in high-speed crystal mode
      if (reqSrc == SRC_PRI && !priReady) begin
        reqSrc = swIf.curSrc;
      end
    end
  end

  // next state
  always_comb begin
    d = q;
    // two-stage pin synchronisers
    d.s1 = {twoSpeedIn, hsModeIn, resetClockDefaultIn,
            cfgLoadedIn, rcOscIn, secOscIn, priOscIn};
    d.s2 = q.s1;
    d.s3 = q.s2[2:0];
    // configuration load picks up the default bit
    if (!q.cfgDone && q.s2[3]) begin
      d.cfgDone = 1'b1;
      d.dfltBit = q.s2[4];
    end
    // start-up timer on primary edges
    if (q.cfgDone && hsS && !q.startDone && tickS[SRC_PRI]) begin
      if (q.startCnt == START_CYCLES - 11'h1) begin
        d.startDone = 1'b1;
      end else begin
        d.startCnt = q.startCnt + 11'h1;
      end
    end
    // status flags, never both set
    d.t1Act = swIf.curSrc == SRC_SEC && swIf.gateOn;
    d.startFlag = q.cfgDone && priReady && !d.t1Act;
    // sleep entry and wake
    if (wakeEvent) begin
      d.slp = 1'b0;
      d.idl = 1'b0;
    end else if (sleepExec && !q.slp && !q.idl) begin
      d.idl = q.idle;
      d.slp = !q.idle;
    end
    // gated device clock, stopped in sleep
    d.clkEn = swIf.gateOn && tickS[swIf.curSrc] && !q.slp;
    // axi write channels, taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.awHeld = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.wHeld = 1'b1;
      d.wData = s_axi_wdata[7:0];
      d.wEn = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // both halves present: apply and answer
    if (q.awHeld && q.wHeld && !q.bvalid) begin
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.awAddr == OSC_CTRL_OFS) begin
        if (q.wEn) begin
          d.idle = q.wData[IDLE_BIT];
          d.sel = q.wData[1:0];
        end
      end else if (q.awAddr == T1_CTRL_OFS) begin
        if (q.wEn) begin
          d.t1en = q.wData[T1EN_BIT];
        end
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end
    d.awready = !d.awHeld && !d.bvalid;
    d.wready = !d.wHeld && !d.bvalid;
    // axi read, one outstanding
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 8'h00;
      if (s_axi_araddr == OSC_CTRL_OFS) begin
        d.rdata[IDLE_BIT] = q.idle;
        d.rdata[START_FLAG_BIT] = q.startFlag;
        d.rdata[1:0] = q.sel;
      end else if (s_axi_araddr == T1_CTRL_OFS) begin
        d.rdata[T1ACT_BIT] = q.t1Act;
        d.rdata[T1EN_BIT] = q.t1en;
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end
    d.arready = !d.rvalid;
    // synchronous reset, sync stages keep sampling
    if (sys_rst) begin
      d.idle = IDLE_RST;
      d.sel = SEL_RST;
      d.t1en = 1'b0;
      d.dfltBit = DFLT_BIT_RST;
      d.cfgDone = 1'b0;
      d.startCnt = 11'h000;
      d.startDone = 1'b0;
      d.startFlag = !(q.s2[5] && q.s2[6]);
      d.t1Act = 1'b0;
      d.slp = 1'b0;
      d.idl = 1'b0;
      d.clkEn = 1'b0;
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.awready = 1'b0;
      d.wready = 1'b0;
      d.bvalid = 1'b0;
      d.arready = 1'b0;
      d.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    q <= d;
  end

  // outputs straight from state
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = {24'h00_0000, q.rdata};
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign devClkEn = q.clkEn;
  assign clkSrc = swIf.curSrc;
  assign idleMode = q.idl;
  assign sleepMode = q.slp;
  assign timer1OscRun = q.t1en;
  // RC stays on for watchdog and fail-safe monitor
  assign rcOscRun = 1'b1;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_sel_decode_rc:
    assert property (q.cfgDone && q.sel == SEL_RC
      |-> reqSrc == SRC_RC)
    else $error("select 11 did not ask for RC");
  a_dflt_rc:
    assert property (q.cfgDone && q.sel == SEL_DFLT && !q.dfltBit
      |-> reqSrc == SRC_RC)
    else $error("select 00 ignored default bit");
  a_reset_clear:
    assert property (disable iff (1'b0)
      sys_rst |=> q.sel == SEL_RST && !q.idle && q.dfltBit)
    else $error("reset left select or idle set");
  // three reset edges so the synced mode pins are known
  a_flag_reset:
    assert property (disable iff (1'b0)
      sys_rst [*3] |=> q.startFlag ==
        !($past(q.s2[5]) && $past(q.s2[6])))
    else $error("start-up flag reset value wrong");
  a_boot_rc:
    assert property (!q.cfgDone |-> reqSrc == SRC_RC)
    else $error("left RC before configuration");
  a_flags_excl:
    assert property (!(q.startFlag && q.t1Act))
    else $error("both status flags set");
  a_t1_active:
    assert property (##1 q.t1Act ==
      $past(swIf.curSrc == SRC_SEC && swIf.gateOn))
    else $error("Timer1 active flag wrong");
  a_sec_refused:
    assert property (q.cfgDone && !q.t1en && q.sel == SEL_SEC
      |-> reqSrc != SRC_SEC || swIf.curSrc == SRC_SEC)
    else $error("Timer1 selected while disabled");
  a_sleep_kind:
    assert property (sleepExec && !wakeEvent && !q.slp && !q.idl
      |=> q.idl == $past(q.idle) && q.slp == !$past(q.idle))
    else $error("wrong power mode on sleep");
  a_start_gate:
    assert property (q.cfgDone && hsS && !q.startDone
      |-> reqSrc != SRC_PRI)
    else $error("primary chosen before start-up timer");
endmodule // clksw_top

// ---- tb/clksw_osc_model.sv ----
// Purpose: oscillator pins that feed the clock switch
// Assumes: pins move just after an mclk edge
// Notes: half periods in mclk cycles, each at least 2
`timescale 1ns/100ps
module clksw_osc_model #(
  parameter int PRI_HALF = 3, // primary half period
  parameter int SEC_HALF = 5, // timer1 crystal half period
  parameter int RC_HALF = 4 // rc half period
) (
  // clock
  input wire logic mclk,
  // timer1 crystal enable as software set it
  input wire logic secRun,
  // oscillator pins
  output logic priOscIn,
  output logic secOscIn,
  output logic rcOscIn
);
  int priCnt = 0; // cycles in the current half
  int secCnt = 0;
  int rcCnt = 0;
  initial begin
    priOscIn = 1'h0;
    secOscIn = 1'h0;
    rcOscIn = 1'h0;
  end
  // rc never stops, it also serves watchdog and monitor
  always @(posedge mclk) begin
    rcCnt <= (rcCnt == RC_HALF - 1) ? 0 : rcCnt + 1;
    if (rcCnt == RC_HALF - 1) rcOscIn <= !rcOscIn;
    priCnt <= (priCnt == PRI_HALF - 1) ? 0 : priCnt + 1;
    if (priCnt == PRI_HALF - 1) priOscIn <= !priOscIn;
  end
  // crystal runs once enabled, whatever the power mode
  always @(posedge mclk) begin
    if (secRun) begin
      secCnt <= (secCnt == SEC_HALF - 1) ? 0 : secCnt + 1;
      if (secCnt == SEC_HALF - 1) secOscIn <= !secOscIn;
    end
  end
endmodule // clksw_osc_model

// ---- tb/clksw_top_tb.sv ----
// Purpose: self-checking bench for the clock source switch
// Assumes: bus tasks start and end just after a rising edge
// Notes: source periods are 6, 10 and 8 mclk cycles
`timescale 1ns/100ps
module clksw_top_tb;
  import clksw_pkg::*;
  // clock, reset and counters
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  int errors = 0;
  int checked = 0;
  // bus
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, clkSrc;
  // pins, config and core
  logic priOscIn, secOscIn, rcOscIn, timer1OscRun, rcOscRun;
  logic cfgLoadedIn = 1'h0, resetClockDefaultIn = 1'h1;
  logic hsModeIn = 1'h1, twoSpeedIn = 1'h1;
  logic sleepExec = 1'h0, wakeEvent = 1'h0;
  logic devClkEn, idleMode, sleepMode;
  logic [31:0] d;
  logic [1:0] r;

  clksw_top clksw_top_i (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .priOscIn, .secOscIn,
    .rcOscIn, .cfgLoadedIn, .resetClockDefaultIn, .hsModeIn, .twoSpeedIn,
    .sleepExec, .wakeEvent, .devClkEn, .clkSrc, .idleMode, .sleepMode,
    .timer1OscRun, .rcOscRun);
  // crystal follows the enable bit, as careful software would
  clksw_osc_model clksw_osc_model_i (.mclk, .secRun(timer1OscRun),
    .priOscIn, .secOscIn, .rcOscIn);

  // 40 MHz
  always #12.5 mclk = !mclk;

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_wstrb <= 4'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (s_axi_awready && !aw) begin
        aw = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready && !w) begin
        w = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge mclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // write, then time the gap until the new source clocks the device
  task automatic sw(input logic [31:0] a, input logic [7:0] v,
                    input clksw_src_t src, input int oldP, input int newP);
    int n;
    // a last old-source pulse may still stand one cycle after the write
    n = 2;
    wr(a, v);
    cyc(2);
    while (devClkEn !== 1'h1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n >= oldP + 3 * newP && n <= 3 * oldP + 5 * newP + 8), 1);
    chk(32'(clkSrc), 32'(src));
  endtask

  task automatic t_reset;
    rd(OSC_CTRL_OFS);
    chk(d, 32'h0000_0000);
    rd(T1_CTRL_OFS);
    chk(d, 32'h0000_0000);
    chk(32'(clkSrc), 32'(SRC_RC));
    chk(32'(rcOscRun), 32'h0000_0001);
    chk(32'(timer1OscRun), 32'h0000_0000);
    $display("reset values done");
  endtask
  // hs crystal must count its start-up before taking over
  task automatic t_startup;
    int n;
    n = 0;
    cfgLoadedIn <= 1'h1;
    while (clkSrc !== SRC_PRI && n < 9000) begin
      @(posedge mclk);
      n++;
      if (n == 300) chk(32'(clkSrc), 32'(SRC_RC));
    end
    chk(32'(n > 6100 && n < 6500), 1);
    rd(OSC_CTRL_OFS);
    chk(d, 32'h0000_0008);
    $display("start-up done");
  endtask
  task automatic t_select;
    sw(OSC_CTRL_OFS, 8'h03, SRC_RC, 6, 8);
    sw(OSC_CTRL_OFS, 8'h02, SRC_PRI, 8, 6);
    wr(OSC_CTRL_OFS, 8'h01);
    cyc(80);
    chk(32'(clkSrc), 32'(SRC_PRI));
    sw(T1_CTRL_OFS, 8'h08, SRC_SEC, 6, 10);
    chk(32'(timer1OscRun), 32'h0000_0001);
    rd(T1_CTRL_OFS);
    chk(d, 32'h0000_0048);
    rd(OSC_CTRL_OFS);
    chk(d, 32'h0000_0001);
    sw(OSC_CTRL_OFS, 8'h00, SRC_PRI, 10, 6);
    rd(T1_CTRL_OFS);
    chk(d, 32'h0000_0008);
    $display("select codes done");
  endtask
  // reserved bits, unmapped place, then both sleep flavours
  task automatic t_bus_sleep;
    int n;
    n = 0;
    sw(OSC_CTRL_OFS, 8'hFF, SRC_RC, 6, 8);
    wr(32'h0000_0010, 8'h00);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(32'h0000_0010);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(OSC_CTRL_OFS);
    chk(d, 32'h0000_008B);
    sleepExec <= 1'h1;
    cyc(1);
    sleepExec <= 1'h0;
    cyc(2);
    chk(32'({idleMode, sleepMode}), 32'h0000_0002);
    wakeEvent <= 1'h1;
    cyc(1);
    wakeEvent <= 1'h0;
    wr(OSC_CTRL_OFS, 8'h03);
    sleepExec <= 1'h1;
    cyc(1);
    sleepExec <= 1'h0;
    cyc(2);
    chk(32'({idleMode, sleepMode}), 32'h0000_0001);
    repeat (40) begin
      @(posedge mclk);
      n += 32'(devClkEn === 1'h1);
    end
    chk(32'(n), 32'h0000_0000);
    wakeEvent <= 1'h1;
    cyc(1);
    wakeEvent <= 1'h0;
    $display("bus and sleep done");
  endtask
  // second reset with the default bit cleared and no crystal timer
  task automatic t_default_rc;
    sys_rst <= 1'h1;
    cfgLoadedIn <= 1'h0;
    resetClockDefaultIn <= 1'h0;
    hsModeIn <= 1'h0;
    cyc(5);
    sys_rst <= 1'h0;
    cfgLoadedIn <= 1'h1;
    cyc(30);
    chk(32'(clkSrc), 32'(SRC_RC));
    rd(OSC_CTRL_OFS);
    chk(d, 32'h0000_0008);
    sw(OSC_CTRL_OFS, 8'h02, SRC_PRI, 8, 6);
    $display("default rc done");
  endtask

  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // about 7000 cycles of work, so 20000 means a hang
  initial begin
    #500000;
    errors++;
    end_of_test();
  end
  initial begin
    cyc(5);
    sys_rst <= 1'h0;
    cyc(1);
    t_reset();
    t_startup();
    t_select();
    t_bus_sleep();
    t_default_rc();
    end_of_test();
  end
endmodule // clksw_top_tb
